/* host_port_params.svh */
// Purpose: Shared constants of the host control port ends
// Assumes: Included by the device, controller and bench files of this block
// Notes:   Times in ns, counts derived at 25 MHz
//
// Operation
// [RL1] Style pin low: direction plus strobe
// [RL2] Chip select high: strobes ignored
// [RL3] Host toggles chip select per access
// [RL4] Serial input sampled on shift rise
// [RL5] Serial output edge by edge select
// [RL6] Direction 0: capture bus on strobe
// [RL7] Direction 1: drive register on strobe
// [RL8] Read strobe low: device drives bus
// [RL9] Write strobe low: device captures bus
// [RL10] Port style pin picks parallel/serial
// [RL11] Host presents address each access
// [RL12] Shared pins interpreted by mode
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH
`define REG_COUNT      16
`define CFG_IDX        4'h0
`define STAT_IDX       4'hF
`define SER_ADDR_FIRST 5'h01
`define SER_ADDR_LAST  5'h08
`define SER_DATA_FIRST 5'h09
`define SER_DATA_LAST  5'h10
`define SER_CNT_MAX    5'h11
`define HS_SMP_FIRST   5'h0A
`define HS_SMP_LAST    5'h11
`define HS_END_CNT     5'h12
`define CLK_MHZ        25
`define SETUP_NS       80
`define STROBE_NS      640
`define GAP_NS         320
`define CYC(ns) (((ns) * `CLK_MHZ + 999) / 1000)
`define SETUP_CYC      8'(`CYC(`SETUP_NS))
`define STROBE_CYC     8'(`CYC(`STROBE_NS))
`define GAP_CYC        8'(`CYC(`GAP_NS))
`define OFS_CTRL       8'h00
`define OFS_ADDR       8'h04
`define OFS_WDATA      8'h08
`define OFS_STATUS     8'h0C
`define OFS_RDATA      8'h10
`define CTRL_GO        0
`define CTRL_RW        1
`define CTRL_PAR       2
`define CTRL_STYLE     3
`define CTRL_EDGE      4
`define STAT_BUSY      0
`define STAT_DONE      1
`endif

/* host_port_pkg.sv */
// Purpose: Types of the host control port ends
// Assumes: Constants come from host_port_params.svh
// Notes:   One state struct per end
package host_port_pkg;
  typedef enum logic [1:0] {P_IDLE, P_READ, P_HOLD} dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE, H_SSTART, H_SER, H_PSET, H_PSTB, H_PREL, H_GAP
  } host_state_t;
  typedef struct packed {
    dev_state_t        st;
    logic [4:0]        cnt;
    logic              rw;
    logic [7:0]        addr;
    logic [7:0]        shift;
    logic              sout;
    logic [7:0]        dout;
    logic              doe;
    logic [15:0][7:0]  regs;
  } dev_regs_t;
  typedef struct packed {
    host_state_t st;
    logic [7:0]  cnt;
    logic [4:0]  bits;
    logic [16:0] frame;
    logic        sclk;
    logic        cs_n;
    logic        ctl_a;
    logic        ctl_b;
    logic [7:0]  hd;
    logic        hoe;
    logic        rw;
    logic        par;
    logic        style;
    logic        edge_sel;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        busy;
    logic        done;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } host_regs_t;
endpackage

/* host_port_if.sv */
// Purpose: Pins between controller and device host port
// Assumes: Controller drives the shift clock freely
// Notes:   Data bus resolved here, pulled high when idle
`timescale 1ns/10ps
interface host_port_if;
  logic       port_par;
  logic       bus_style_select;
  logic       shift_edge_select;
  logic       sclk;
  logic       cs_n;
  logic       ctl_a;
  logic       ctl_b;
  logic [7:0] addr;
  logic [7:0] host_d;
  logic       host_oe;
  logic [7:0] dev_d;
  logic       dev_oe;
  logic       serial_out;
  logic [7:0] data;
  assign data = dev_oe ? dev_d : (host_oe ? host_d : 8'hFF);
  modport host (
    output port_par, bus_style_select, shift_edge_select, sclk,
    output cs_n, ctl_a, ctl_b, addr, host_d, host_oe,
    input  data, serial_out
  );
  modport dev (
    input  port_par, bus_style_select, shift_edge_select, sclk,
    input  cs_n, ctl_a, ctl_b, addr, data,
    output dev_d, dev_oe, serial_out
  );
endinterface

/* dual_flop_sync.sv */
// Purpose: Two flip-flop synchroniser for a group of levels
// Assumes: Each bit is a level held over several cycles
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module dual_flop_sync #(
  parameter int W = 1
) (
  input  wire logic         CLK,
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);
  logic [W-1:0] meta;
  always_ff @(posedge CLK) begin
    meta <= D;
    Q    <= meta;
  end
endmodule

/* host_port_dev.sv */
// Purpose: Device end of the host control port
// Assumes: Shift clock runs freely; SYS_RST is synchronous to it
// Notes:   Sixteen byte registers; index F reads STAT_IN
`timescale 1ns/10ps
`include "host_port_params.svh"
module host_port_dev
  import host_port_pkg::*;
(
  host_port_if.dev        link,
  input  wire logic       SYS_RST,
  input  wire logic [7:0] STAT_IN,
  output logic      [7:0] CFG_OUT
);
  dev_regs_t  r;
  dev_regs_t  next_r;
  logic       sout_fall;
  logic [29:0] sync_in;
  logic [29:0] sync_out;
  logic       par;
  logic       style;
  logic       edge_sel;
  logic       cs_n_s;
  logic       a_s;
  logic       b_s;
  logic [7:0] addr_s;
  logic [7:0] data_s;
  logic [7:0] stat_s;
  logic       cs_act;
  logic       wr_req;
  logic       rd_req;
  logic [7:0] rbyte;
  logic [7:0] sbyte;

  //////////////////////////////////////////////////////////////////////
  // Parallel pins and straps cross in from the controller clock

  assign sync_in = {link.port_par, link.bus_style_select,
                    link.shift_edge_select, link.cs_n, link.ctl_a,
                    link.ctl_b, link.addr, link.data, STAT_IN};

  dual_flop_sync #(
    .W (30)
  ) dual_flop_sync_inst (
    .CLK (link.sclk),
    .D   (sync_in),
    .Q   (sync_out)
  );

  assign par      = sync_out[29];
  assign style    = sync_out[28];
  assign edge_sel = sync_out[27];
  assign cs_n_s   = sync_out[26];
  assign a_s      = sync_out[25];
  assign b_s      = sync_out[24];
  assign addr_s   = sync_out[23:16];
  assign data_s   = sync_out[15:8];
  assign stat_s   = sync_out[7:0];

  //////////////////////////////////////////////////////////////////////
  // Register map decoding, shared by serial and parallel paths

  function automatic logic in_map(input logic [7:0] a);
    in_map = (a < 8'(`REG_COUNT));
  endfunction

  function automatic logic [7:0] read_reg(
    input dev_regs_t  s,
    input logic [7:0] a,
    input logic [7:0] st
  );
    read_reg = 8'h00;
    if (in_map(a)) begin
      if (a[3:0] == `STAT_IDX) begin
        read_reg = st;
      end else begin
        read_reg = s.regs[a[3:0]];
      end
    end
  endfunction

  function automatic logic writable(input logic [7:0] a);
    writable = in_map(a) && (a[3:0] != `STAT_IDX);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Parallel request decoding

  // [RL2] Chip select gate
  assign cs_act = par && !cs_n_s;

  // [RL12] Shared pin roles
  always_comb begin
    if (style) begin
      // [RL9] Write strobe low
      wr_req = cs_act && !a_s;
      // [RL8] Read strobe low
      rd_req = cs_act && !b_s;
    end else begin
      // [RL6] Strobe with direction 0
      wr_req = cs_act && !b_s && !a_s;
      // [RL7] Strobe with direction 1
      rd_req = cs_act && !b_s && a_s;
    end
  end

  assign rbyte = read_reg(r, addr_s, stat_s);
  assign sbyte = read_reg(r, r.addr, stat_s);

  //////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_r = r;
    // [RL10] Port style select
    if (par) begin
      next_r.cnt  = 5'h00;
      next_r.sout = 1'b0;
      // [RL1] Parallel style by pin
      case (r.st)
        P_IDLE: begin
          next_r.doe = 1'b0;
          if (wr_req && !rd_req) begin
            if (writable(addr_s)) begin
              next_r.regs[addr_s[3:0]] = data_s;
            end
            next_r.st = P_HOLD;
          end else if (rd_req && !wr_req) begin
            next_r.dout = rbyte;
            next_r.doe  = 1'b1;
            next_r.st   = P_READ;
          end
        end
        P_READ: begin
          if (!rd_req) begin
            next_r.doe = 1'b0;
            next_r.st  = P_IDLE;
          end
        end
        P_HOLD: begin
          if (!wr_req) begin
            next_r.st = P_IDLE;
          end
        end
        default: begin
          next_r.doe = 1'b0;
          next_r.st  = P_IDLE;
        end
      endcase
    end else begin
      next_r.st  = P_IDLE;
      next_r.doe = 1'b0;
      // [RL2] Frame only while selected
      if (link.cs_n) begin
        next_r.cnt  = 5'h00;
        next_r.sout = 1'b0;
      end else begin
        if (r.cnt != `SER_CNT_MAX) begin
          next_r.cnt = r.cnt + 5'h01;
        end
        // [RL4] Sample on rising edge
        if (r.cnt == 5'h00) begin
          next_r.rw = link.ctl_a;
        end else if (r.cnt <= `SER_ADDR_LAST) begin
          next_r.addr = {r.addr[6:0], link.ctl_a};
        end else if (r.cnt <= `SER_DATA_LAST) begin
          if (r.rw) begin
            // [RL5] Launch on rising edge
            if (r.cnt == `SER_DATA_FIRST) begin
              next_r.sout  = sbyte[7];
              next_r.shift = {sbyte[6:0], 1'b0};
            end else begin
              next_r.sout  = r.shift[7];
              next_r.shift = {r.shift[6:0], 1'b0};
            end
          end else begin
            next_r.shift = {r.shift[6:0], link.ctl_a};
            if ((r.cnt == `SER_DATA_LAST) && writable(r.addr)) begin
              next_r.regs[r.addr[3:0]] = {r.shift[6:0], link.ctl_a};
            end
          end
        end else begin
          next_r.sout = 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // State register on the shift clock

  always_ff @(posedge link.sclk) begin
    if (SYS_RST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // [RL5] Falling edge relaunch
  always_ff @(negedge link.sclk) begin
    if (SYS_RST) begin
      sout_fall <= 1'b0;
    end else begin
      sout_fall <= r.sout;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs

  // [RL5] Edge select mux
  assign link.serial_out = edge_sel ? sout_fall : r.sout;
  // [RL7] Drive bus while reading
  assign link.dev_d      = r.dout;
  assign link.dev_oe     = r.doe;
  assign CFG_OUT         = r.regs[`CFG_IDX];

endmodule

/* host_port_ctl.sv */
// Purpose: Controller end: APB registers to host port pins
// Assumes: APB master follows the usual setup/access order
// Notes:   Shift clock is CLK divided by two, held low only while SYS_RST is high
`timescale 1ns/10ps
`include "host_port_params.svh"
module host_port_ctl
  import host_port_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  host_port_if.host        link
);
  host_regs_t r;
  host_regs_t next_r;
  logic [7:0] data_s;
  logic       acc;
  logic       commit;
  logic       rise;

  dual_flop_sync #(
    .W (8)
  ) dual_flop_sync_inst (
    .CLK (CLK),
    .D   (link.data),
    .Q   (data_s)
  );

  assign acc  = PSEL && PENABLE && !r.pready;
  // Writes land at the edge where the master sees PREADY high
  assign commit = PSEL && PENABLE && PWRITE && r.pready;
  assign rise = !r.sclk;

  //////////////////////////////////////////////////////////////////////
  // APB slave and access sequencer

  always_comb begin
    next_r         = r;
    next_r.sclk    = !r.sclk;
    next_r.pready  = acc;
    next_r.pslverr = 1'b0;
    next_r.prdata  = 32'h0000_0000;
    if (acc) begin
      case (PADDR)
        `OFS_CTRL:   next_r.prdata = {27'h0, r.edge_sel, r.style,
                                      r.par, r.rw, r.busy};
        `OFS_ADDR:   next_r.prdata = {24'h0, r.addr};
        `OFS_WDATA:  next_r.prdata = {24'h0, r.wdata};
        `OFS_STATUS: next_r.prdata = {30'h0, r.done, r.busy};
        `OFS_RDATA:  next_r.prdata = {24'h0, r.rdata};
        default:     next_r.pslverr = 1'b1;
      endcase
      if (PWRITE) begin
        next_r.prdata = 32'h0000_0000;
      end
    end
    if (commit) begin
      if (!r.busy) begin
        case (PADDR)
          `OFS_CTRL: begin
            next_r.rw       = PWDATA[`CTRL_RW];
            next_r.par      = PWDATA[`CTRL_PAR];
            next_r.style    = PWDATA[`CTRL_STYLE];
            next_r.edge_sel = PWDATA[`CTRL_EDGE];
            if (PWDATA[`CTRL_GO]) begin
              next_r.busy = 1'b1;
              next_r.done = 1'b0;
              next_r.st   = PWDATA[`CTRL_PAR] ? H_PSET : H_SSTART;
            end
          end
          `OFS_ADDR:  next_r.addr  = PWDATA[7:0];
          `OFS_WDATA: next_r.wdata = PWDATA[7:0];
          default: begin
          end
        endcase
      end
      if ((PADDR == `OFS_STATUS) && PWDATA[`STAT_DONE]) begin
        next_r.done = 1'b0;
      end
    end
    case (r.st)
      H_IDLE: begin
        next_r.cs_n  = 1'b1;
        next_r.ctl_a = 1'b1;
        next_r.ctl_b = 1'b1;
        next_r.hoe   = 1'b0;
      end
      H_SSTART: begin
        if (!rise) begin
          // [RL3] Select low per frame
          next_r.cs_n  = 1'b0;
          next_r.ctl_a = r.rw;
          next_r.frame = {r.rw, r.addr, r.wdata} << 1;
          next_r.bits  = 5'h00;
          next_r.st    = H_SER;
        end
      end
      H_SER: begin
        if (rise) begin
          next_r.bits = r.bits + 5'h01;
        end else begin
          next_r.ctl_a = r.frame[16];
          next_r.frame = r.frame << 1;
        end
        if (r.rw && (r.bits >= `HS_SMP_FIRST) &&
            (r.bits <= `HS_SMP_LAST) && (rise == r.edge_sel)) begin
          next_r.rdata = {r.rdata[6:0], link.serial_out};
        end
        if (!rise && (r.bits == `HS_END_CNT)) begin
          next_r.cs_n  = 1'b1;
          next_r.ctl_a = 1'b1;
          next_r.cnt   = `GAP_CYC;
          next_r.st    = H_GAP;
        end
      end
      H_PSET: begin
        // [RL11] Address for each access
        next_r.cs_n    = 1'b0;
        next_r.ctl_a   = r.style ? 1'b1 : r.rw;
        next_r.ctl_b   = 1'b1;
        next_r.hd      = r.wdata;
        next_r.hoe     = !r.rw;
        next_r.cnt     = `SETUP_CYC;
        next_r.st      = H_PSTB;
      end
      H_PSTB: begin
        next_r.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h01) begin
          next_r.cnt = `STROBE_CYC;
          if (r.style && !r.rw) begin
            next_r.ctl_a = 1'b0;
          end else begin
            next_r.ctl_b = 1'b0;
          end
          next_r.st = H_PREL;
        end
      end
      H_PREL: begin
        next_r.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h01) begin
          next_r.rdata = r.rw ? data_s : r.rdata;
          next_r.ctl_a = r.style ? 1'b1 : r.rw;
          next_r.ctl_b = 1'b1;
          next_r.cnt   = `GAP_CYC;
          next_r.st    = H_GAP;
        end
      end
      H_GAP: begin
        // [RL3] Select high between accesses
        next_r.cs_n  = 1'b1;
        next_r.hoe   = 1'b0;
        next_r.cnt   = r.cnt - 8'h01;
        if (r.cnt == 8'h01) begin
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.st   = H_IDLE;
        end
      end
      default: next_r.st = H_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      r       <= '0;
      r.cs_n  <= 1'b1;
      r.ctl_a <= 1'b1;
      r.ctl_b <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign PRDATA                 = r.prdata;
  assign PREADY                 = r.pready;
  assign PSLVERR                = r.pslverr;
  assign link.port_par          = r.par;
  assign link.bus_style_select  = r.style;
  assign link.shift_edge_select = r.edge_sel;
  assign link.sclk              = r.sclk;
  assign link.cs_n              = r.cs_n;
  assign link.ctl_a             = r.ctl_a;
  assign link.ctl_b             = r.ctl_b;
  assign link.addr              = r.addr;
  assign link.host_d            = r.hd;
  assign link.host_oe           = r.hoe;
endmodule

/* host_port_sva.sv */
// Purpose: Checker on the pins between controller and device
// Assumes: SYS_RST is the device-side reset, CLK the controller clock
// Notes:   Shift clock is CLK divided by two
`timescale 1ns/10ps
module host_port_sva (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       port_par,
  input wire logic       bus_style_select,
  input wire logic       shift_edge_select,
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       ctl_a,
  input wire logic       ctl_b,
  input wire logic       host_oe,
  input wire logic       dev_oe,
  input wire logic       serial_out
);
  //////////////////////////////////////////////////////////////////////////
  a_idle_quiet: assert property (@(posedge sclk)
    disable iff (SYS_RST)
    cs_n [*6] |-> !dev_oe) else $error("device drives while deselected");
  a_style0_read: assert property (@(posedge sclk)
    disable iff (SYS_RST)
    (port_par && !bus_style_select && !cs_n && ctl_a && !ctl_b) [*6]
    |-> dev_oe) else $error("style 0 read not driven");
  a_style0_write: assert property (@(posedge sclk)
    disable iff (SYS_RST)
    (port_par && !bus_style_select && !cs_n && !ctl_a && !ctl_b) [*4]
    |-> !dev_oe) else $error("style 0 write driven by device");
  a_style1_read: assert property (@(posedge sclk)
    disable iff (SYS_RST)
    (port_par && bus_style_select && !cs_n && ctl_a && !ctl_b) [*6]
    |-> dev_oe) else $error("style 1 read not driven");
  a_style1_write: assert property (@(posedge sclk)
    disable iff (SYS_RST)
    (port_par && bus_style_select && !cs_n && !ctl_a && ctl_b) [*4]
    |-> !dev_oe) else $error("style 1 write driven by device");
  a_serial_quiet: assert property (@(posedge sclk)
    disable iff (SYS_RST)
    (!port_par) [*6] |-> !dev_oe) else $error("bus driven in serial mode");
  a_no_clash: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    !(dev_oe && host_oe)) else $error("both ends drive the bus");
  a_launch_rise: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    (!shift_edge_select && shift_edge_select == $past(shift_edge_select, 8)
    && $changed(serial_out)) |-> $rose(sclk))
    else $error("serial out moved off rising edge");
  a_launch_fall: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    (shift_edge_select && shift_edge_select == $past(shift_edge_select, 8)
    && $changed(serial_out)) |-> $fell(sclk))
    else $error("serial out moved off falling edge");
  a_cs_gap: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    $rose(cs_n) |-> cs_n [*8]) else $error("chip select gap too short");
endmodule

/* host_port_control_bench.sv */
// Purpose: Drives the controller over APB against the device end
// Assumes: Device reset released after the shift clock runs
// Notes:   Each transfer is set up, then started, then polled
`timescale 1ns/10ps
`include "host_port_params.svh"
module host_control_port_bench;
  logic        CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        dev_rst = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic [7:0]  STAT_IN = 8'h00;
  logic [7:0]  CFG_OUT;
  logic [31:0] rd;
  logic        err;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;

  host_port_if link();
  host_port_ctl host_port_ctl_inst (.CLK(CLK), .SYS_RST(SYS_RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .link(link));
  host_port_dev host_port_dev_inst (.link(link), .SYS_RST(dev_rst),
    .STAT_IN(STAT_IN), .CFG_OUT(CFG_OUT));
  host_port_sva host_port_sva_inst (.CLK(CLK), .SYS_RST(dev_rst),
    .port_par(link.port_par), .bus_style_select(link.bus_style_select),
    .shift_edge_select(link.shift_edge_select), .sclk(link.sclk),
    .cs_n(link.cs_n), .ctl_a(link.ctl_a), .ctl_b(link.ctl_b),
    .host_oe(link.host_oe), .dev_oe(link.dev_oe),
    .serial_out(link.serial_out));

  always #20 CLK = ~CLK;

  //////////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      print_verdict;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Mode settles on the pins before the transfer is started
  task op(input logic [4:0] cfg, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, `OFS_ADDR, {24'h0, a}, rd, err);
    apb(1'b1, `OFS_WDATA, {24'h0, d}, rd, err);
    apb(1'b1, `OFS_CTRL, {27'h0, cfg}, rd, err);
    repeat (8) @(posedge CLK);
    apb(1'b1, `OFS_CTRL, {27'h0, cfg} | 32'h1, rd, err);
    rd = 32'h0;
    while (rd[`STAT_DONE] !== 1'b1)
      apb(1'b0, `OFS_STATUS, 32'h0, rd, err);
    apb(1'b1, `OFS_STATUS, 32'h2, rd, err);
    apb(1'b0, `OFS_RDATA, 32'h0, rd, err);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge CLK);
    SYS_RST <= 1'b0;
    repeat (8) @(posedge CLK);
    dev_rst <= 1'b0;
    STAT_IN <= 8'hC3;
    @(posedge CLK);
    check({24'h0, CFG_OUT}, 32'h0);
    op(5'h04, 8'h01, 8'hA5);
    op(5'h06, 8'h01, 8'h00);
    check(rd, 32'hA5);
    op(5'h0C, 8'h02, 8'h3C);
    op(5'h0E, 8'h02, 8'h00);
    check(rd, 32'h3C);
    op(5'h0E, 8'h01, 8'h00);
    check(rd, 32'hA5);
    op(5'h04, 8'h00, 8'h5A);
    check({24'h0, CFG_OUT}, 32'h5A);
    op(5'h00, 8'h03, 8'h96);
    op(5'h06, 8'h03, 8'h00);
    check(rd, 32'h96);
    op(5'h02, 8'h03, 8'h00);
    check(rd, 32'h96);
    op(5'h12, 8'h0F, 8'h00);
    check(rd, 32'hC3);
    op(5'h00, 8'h0F, 8'h11);
    op(5'h16, 8'h0F, 8'h00);
    check(rd, 32'hC3);
    op(5'h02, 8'h20, 8'h00);
    check(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0, rd, err);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b0, `OFS_WDATA, 32'h0, rd, err);
    check(rd, 32'h0);
    apb(1'b0, `OFS_CTRL, 32'h0, rd, err);
    check(rd & 32'h1, 32'h0);
    print_verdict;
  end
endmodule
